// ===== rtl/uar_rx_recovery.sv
// Start-bit validation and majority-vote bit recovery of a serial receiver.
// Summary of operation
// - Sixteen samples per bit, eight in double speed.
// - Falling edge starts detection; first low sample one.
// - Start vote on samples 8-10, or 4-6.
// - Majority high start is noise; wait again.
// - Valid start realigns bit timing every frame.
// - Per-bit states sixteen or eight; index equals state.
// - Each bit takes majority of three centre samples.
// - Votes begin at sample 8 or 4.
// - Recover through first stop bit; ignore others.
// - Voted stop bit zero sets frame error.
// - Next falling edge accepted right after stop vote.
// - Frame holds five to ten data plus parity bits.
// - Clearing receiver enable abandons the frame at once.
`timescale 1ns/10ps
module uar_rx_recovery (
  input  wire logic            clk_sys_in,             // System clock, 250 MHz.
  input  wire logic            rstn_in,                // Asynchronous reset, active low.
  input  wire logic            clk_en_in,              // Freezes all state while low.
  input  wire logic            sample_tick_in,         // One pulse per receive sample.
  input  wire logic            double_speed_select_in, // High selects eight samples per bit.
  input  wire logic            receiver_enable_in,     // Low stops the receiver at once.
  input  wire logic            serial_receive_line_in, // Receive line, idle high.
  input  wire logic [3:0]      frame_bits_in,          // Data plus parity bits, 5 to 10.
  output logic                 rx_valid_out,           // A recovered frame is offered.
  input  wire logic            rx_ready_in,            // Consumer takes the frame.
  output uar_pkg::uar_word_t   rx_word_out,            // Oldest recovered frame.
  output logic                 frame_error_flag_out,   // Stop bit of offered frame read low.
  output logic                 overrun_out,            // Frame dropped, buffer full.
  output logic                 rx_busy_out             // A frame is in progress.
);
  import uar_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************

  uar_state_t  state_reg;      // Current receiver state.
  uar_state_t  state_next;     // Next receiver state.
  logic [4:0]  cnt_reg;        // Sample number within the current bit.
  logic [4:0]  cnt_next;       // Next sample number.
  logic [3:0]  bit_idx_reg;    // Data or parity bit being recovered.
  logic [3:0]  bit_idx_next;   // Next bit index.
  logic [9:0]  shift_reg;      // Recovered bits, newest at the top.
  logic [9:0]  shift_next;     // Next shift contents.
  logic        armed_reg;      // Line seen high since the last frame.
  logic        armed_next;     // Next armed value.
  logic        v0_reg;         // First voting sample.
  logic        v1_reg;         // Second voting sample.
  logic        overrun_reg;    // Drop pulse register.
  logic        tick;           // Qualified sample pulse.
  logic [4:0]  spb;            // Samples per bit in the current mode.
  logic [4:0]  first;          // First voting sample number.
  logic [4:0]  last;           // Last voting sample number.
  logic        at_first;       // Sample is the first vote.
  logic        at_mid;         // Sample is the middle vote.
  logic        at_last;        // Sample is the last vote.
  logic        at_end;         // Sample is the last of the bit.
  logic        vote_now;       // Majority of the three voting samples.
  logic [3:0]  fbits;          // Frame size clamped to its legal range.
  logic        last_bit;       // Current data bit is the final one.
  logic        push_valid;     // A frame is handed to the buffer.
  logic        push_ready;     // Buffer has room.
  uar_word_t   push_word;      // Frame handed to the buffer.
  logic [10:0] buf_out;        // Raw buffer output.

  // ****************************************************************
  // Decoding
  // ****************************************************************

  // Samples are counted only on enabled ticks.
  assign tick     = clk_en_in & sample_tick_in & receiver_enable_in;
  // A mode change takes effect at the next tick; changing it inside a
  // frame can move the count past the window, so the mode should only
  // change while the receiver is idle.
  // Mode picks the bit length and the voting window.
  assign spb      = double_speed_select_in ? UAR_SPB_DOUBLE : UAR_SPB_NORMAL;
  assign first    = double_speed_select_in ? UAR_FIRST_DOUBLE : UAR_FIRST_NORMAL;
  assign last     = first + UAR_VOTE_SPAN;
  assign at_first = (cnt_reg == first);
  assign at_mid   = (cnt_reg == first + 5'h01);
  assign at_last  = (cnt_reg == last);
  assign at_end   = (cnt_reg == spb);
  // Two of three decides; the third sample is the live line.
  assign vote_now = (v0_reg & v1_reg) | (v0_reg & serial_receive_line_in)
                  | (v1_reg & serial_receive_line_in);
  // Out-of-range sizes are held to five or ten bits.
  assign fbits    = (frame_bits_in < UAR_FRAME_MIN) ? UAR_FRAME_MIN :
                    (frame_bits_in > UAR_FRAME_MAX) ? UAR_FRAME_MAX : frame_bits_in;
  assign last_bit = (bit_idx_reg == fbits - 4'h1);
  // The frame leaves at the stop-bit vote.
  assign push_valid = (state_reg == UAR_STOP) & tick & at_last;
  assign push_word.frame_error = ~vote_now;
  assign push_word.data        = shift_reg >> (UAR_FRAME_MAX - fbits);
  assign rx_busy_out = (state_reg != UAR_IDLE);
  assign overrun_out = overrun_reg;
  assign rx_word_out = uar_word_t'(buf_out);
  assign frame_error_flag_out = rx_valid_out & rx_word_out.frame_error;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************

  // Walks start, data and stop bits one sample tick at a time.
  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    bit_idx_next = bit_idx_reg;
    shift_next   = shift_reg;
    armed_next   = armed_reg;
    if (tick) begin
      unique case (state_reg)
        UAR_IDLE: begin
          // A low sample that was not preceded by a high one is ignored.
          if (serial_receive_line_in) begin
            armed_next = 1'b1;
          end else if (armed_reg) begin
            // First low sample after high is sample one.
            state_next = UAR_START;
            cnt_next   = UAR_SAMPLE_ONE;
            armed_next = 1'b0;
          end
        end
        UAR_START: begin
          cnt_next = cnt_reg + 5'h01;
          // The count runs on through the vote; a low vote waits for the bit end.
          if (at_last && vote_now) begin
            // A high majority is a noise spike.
            state_next = UAR_IDLE;
          end else if (at_end) begin
            // Bit timing restarts from this start bit.
            state_next   = UAR_DATA;
            cnt_next     = UAR_SAMPLE_ONE;
            bit_idx_next = 4'h0;
          end
        end
        UAR_DATA: begin
          cnt_next = cnt_reg + 5'h01;
          if (at_last) begin
            // Bits arrive least significant first.
            shift_next = {vote_now, shift_reg[9:1]};
          end
          if (at_end) begin
            cnt_next = UAR_SAMPLE_ONE;
            if (last_bit) begin
              state_next = UAR_STOP;
            end else begin
              bit_idx_next = bit_idx_reg + 4'h1;
            end
          end
        end
        UAR_STOP: begin
          cnt_next = cnt_reg + 5'h01;
          if (at_last) begin
            // The buffer strobe pushes the word on this same tick.
            // Later stop bits are never looked at.
            state_next = UAR_IDLE;
            armed_next = vote_now;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // State registers
  // ****************************************************************

  // Disabling the receiver drops the frame and the arming.
  // The shift contents stay; the next frame overwrites them.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg   <= UAR_IDLE;
      cnt_reg     <= '0;
      bit_idx_reg <= '0;
      shift_reg   <= '0;
      armed_reg   <= 1'b0;
    end else if (clk_en_in) begin
      if (!receiver_enable_in) begin
        state_reg   <= UAR_IDLE;
        cnt_reg     <= '0;
        bit_idx_reg <= '0;
        armed_reg   <= 1'b0;
      end else begin
        state_reg   <= state_next;
        cnt_reg     <= cnt_next;
        bit_idx_reg <= bit_idx_next;
        shift_reg   <= shift_next;
        armed_reg   <= armed_next;
      end
    end
  end

  // Holds the first two voting samples of each bit.
  // The third sample is never stored; the live line stands in for it.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      v0_reg <= 1'b0;
      v1_reg <= 1'b0;
    end else if (tick) begin
      if (at_first) begin
        v0_reg <= serial_receive_line_in;
      end
      if (at_mid) begin
        v1_reg <= serial_receive_line_in;
      end
    end
  end

  // Flags a frame that found no room in the buffer.
  // The pulse lasts one cycle and the dropped frame is gone for good.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      overrun_reg <= 1'b0;
    end else if (clk_en_in) begin
      overrun_reg <= push_valid & ~push_ready;
    end
  end

  // ****************************************************************
  // Output buffer
  // ****************************************************************

  // Two frames ride out a stalled consumer; disable flushes them.
  // A full buffer refuses the next frame instead of overwriting the oldest.
  uar_buf2 #(
    .W     ($bits(uar_word_t)),
    .DEPTH (UAR_BUF_DEPTH)
  ) u_buf (
    .clk_sys_in    (clk_sys_in),
    .rstn_in       (rstn_in),
    .clk_en_in     (clk_en_in),
    .flush_in      (~receiver_enable_in),
    .in_valid_in   (push_valid),
    .in_ready_out  (push_ready),
    .in_data_in    (push_word),
    .out_valid_out (rx_valid_out),
    .out_ready_in  (rx_ready_in),
    .out_data_out  (buf_out)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************

  // All checks run on the system clock and sleep during reset.
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  // Start vote taken at the last voting sample.
  sequence s_start_vote;
    state_reg == UAR_START && tick && at_last;
  endsequence
  // Final sample of the final data bit.
  sequence s_last_data;
    state_reg == UAR_DATA && tick && at_end && last_bit;
  endsequence
  // Stop bit vote.
  sequence s_stop_vote;
    state_reg == UAR_STOP && tick && at_last;
  endsequence

  // Start detection and validation.

  a_first_low_one: assert property (
    state_reg == UAR_IDLE && tick && !serial_receive_line_in && armed_reg
    |=> state_reg == UAR_START && cnt_reg == UAR_SAMPLE_ONE)
    else $error("First low sample did not start detection.");
  a_start_reject: assert property (
    s_start_vote ##0 vote_now |=> state_reg == UAR_IDLE && !armed_reg)
    else $error("Noisy start bit was not rejected.");
  a_start_accept: assert property (
    s_start_vote ##0 !vote_now && receiver_enable_in |=> state_reg == UAR_START)
    else $error("Valid start bit was rejected.");
  // Bit recovery and sample counting.
  a_vote_window: assert property (
    state_reg != UAR_IDLE && tick && cnt_reg == (double_speed_select_in ? 5'h04 : 5'h08)
    |=> v0_reg == $past(serial_receive_line_in))
    else $error("First voting sample not taken at its sample number.");
  a_count_range: assert property (
    state_reg != UAR_IDLE |-> cnt_reg >= 5'h01 && cnt_reg <= 5'h10)
    else $error("Sample index out of range.");
  a_data_shift: assert property (
    state_reg == UAR_DATA && tick && at_last |=> shift_reg[9] == $past(vote_now))
    else $error("Voted bit not stored.");
  // Stop bit and restart.
  a_stop_reached: assert property (
    s_last_data |=> state_reg == UAR_STOP && cnt_reg == UAR_SAMPLE_ONE)
    else $error("Stop bit not entered after last data bit.");
  a_stop_error: assert property (
    s_stop_vote ##0 push_ready && !rx_valid_out
    |=> rx_valid_out && frame_error_flag_out == !$past(vote_now))
    else $error("Frame error flag wrong.");
  a_early_rearm: assert property (
    s_stop_vote ##0 vote_now |=> state_reg == UAR_IDLE && armed_reg)
    else $error("Receiver not ready for next start bit.");
  // An unarmed low sample must not open a frame.
  a_need_high: assert property (
    state_reg == UAR_IDLE && tick && !serial_receive_line_in && !armed_reg |=> state_reg == UAR_IDLE)
    else $error("Low line opened a frame without a high sample first.");
  // Receiver disable.
  a_enable_abort: assert property (
    clk_en_in && !receiver_enable_in |=> state_reg == UAR_IDLE && !rx_valid_out)
    else $error("Disable did not abandon the frame.");

endmodule

// ===== rtl/uar_pkg.sv
// Shared constants and types of the asynchronous receive recovery block.
package uar_pkg;

  // ****************************************************************
  // Sampling geometry
  // ****************************************************************

  // Samples per bit in normal mode.
  localparam logic [4:0] UAR_SPB_NORMAL   = 5'h10;
  // Samples per bit in double-speed mode.
  localparam logic [4:0] UAR_SPB_DOUBLE   = 5'h08;
  // First voting sample in normal mode.
  localparam logic [4:0] UAR_FIRST_NORMAL = 5'h08;
  // First voting sample in double-speed mode.
  localparam logic [4:0] UAR_FIRST_DOUBLE = 5'h04;
  // Distance from the first to the last voting sample.
  localparam logic [4:0] UAR_VOTE_SPAN    = 5'h02;
  // Number of the first low sample of a start bit.
  localparam logic [4:0] UAR_SAMPLE_ONE   = 5'h01;

  // ****************************************************************
  // Frame geometry
  // ****************************************************************

  // Fewest data plus parity bits in a frame.
  localparam logic [3:0] UAR_FRAME_MIN    = 4'h5;
  // Most data plus parity bits in a frame.
  localparam logic [3:0] UAR_FRAME_MAX    = 4'ha;
  // Entries of the output buffer.
  localparam int         UAR_BUF_DEPTH    = 2;

  // ****************************************************************
  // Types
  // ****************************************************************

  // Receiver states.
  typedef enum logic [1:0] {
    UAR_IDLE,
    UAR_START,
    UAR_DATA,
    UAR_STOP
  } uar_state_t;

  // One received frame as it leaves the block.
  typedef struct packed {
    logic       frame_error;
    logic [9:0] data;
  } uar_word_t;

endpackage

// ===== rtl/uar_buf2.sv
// Small flip-flop buffer with valid and ready on both sides.
`timescale 1ns/10ps
module uar_buf2 #(
  parameter int W     = 11,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_sys_in,   // System clock.
  input  wire logic         rstn_in,      // Asynchronous reset, active low.
  input  wire logic         clk_en_in,    // Freezes all state while low.
  input  wire logic         flush_in,     // Empties the buffer.
  input  wire logic         in_valid_in,  // Word offered on the fill side.
  output logic              in_ready_out, // Room for a word.
  input  wire logic [W-1:0] in_data_in,   // Word on the fill side.
  output logic              out_valid_out,// Word available on the drain side.
  input  wire logic         out_ready_in, // Drain side takes the word.
  output logic [W-1:0]      out_data_out  // Oldest word.
);

  // ****************************************************************
  // Storage and pointers
  // ****************************************************************

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_reg [DEPTH];   // Entries, each a row of flip-flops.
  logic [AW-1:0] wr_ptr_reg;        // Next entry to fill.
  logic [AW-1:0] rd_ptr_reg;        // Oldest entry.
  logic [AW:0]   count_reg;         // Entries in use.
  logic [AW-1:0] wr_ptr_next;       // Write pointer after a push.
  logic [AW-1:0] rd_ptr_next;       // Read pointer after a pop.
  logic          push;              // A word enters.
  logic          pop;               // A word leaves.

  // Full and empty come straight from the count.
  assign in_ready_out  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out  = mem_reg[rd_ptr_reg];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;
  assign wr_ptr_next   = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
  assign rd_ptr_next   = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;

  // Each entry loads when the write pointer points at it.
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
        mem_reg[i] <= '0;
      end else if (clk_en_in && push && !flush_in && wr_ptr_reg == AW'(i)) begin
        mem_reg[i] <= in_data_in;
      end
    end
  end

  // Pointers and count; a flush drops everything held.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (clk_en_in) begin
      if (flush_in) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
        count_reg  <= '0;
      end else begin
        if (push) begin
          wr_ptr_reg <= wr_ptr_next;
        end
        if (pop) begin
          rd_ptr_reg <= rd_ptr_next;
        end
        count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
    end
  end

endmodule

// ===== tb/uar_tx_model.sv
// Behavioural remote serial transmitter that drives the receive line.
`timescale 1ns/10ps
module uar_tx_model (
  input  wire logic clk_sys_in, // System clock.
  output logic      line_out    // Serial line, idle high.
);
  // ****************************************************************
  // Line driver
  // ****************************************************************

  // The line rests high between frames.
  initial line_out = 1'b1;

  // Sends start, nbits LSB first, then one stop bit of stop_clks cycles.
  // A glitch_bit index flips two mid-bit cycles of that bit only.
  task automatic send(input logic [9:0] data, input int nbits, input logic stop,
                      input int bit_clks, input int stop_clks, input int glitch_bit);
    logic v;
    int   n;
    for (int i = -1; i <= nbits; i++) begin
      v = (i < 0) ? 1'b0 : (i >= nbits) ? stop : data[i];
      n = (i >= nbits) ? stop_clks : bit_clks;
      for (int c = 0; c < n; c++) begin
        @(posedge clk_sys_in);
        line_out <= #1 (i == glitch_bit && c >= n / 2 && c < n / 2 + 2) ? ~v : v;
      end
    end
    @(posedge clk_sys_in);
    line_out <= #1 1'b1;
    // Returns just after the edge so that the caller drives off the edge.
    #1;
  endtask

  // Short low spike that is not a real start bit.
  task automatic spike(input int n);
    @(posedge clk_sys_in);
    line_out <= #1 1'b0;
    repeat (n) @(posedge clk_sys_in);
    line_out <= #1 1'b1;
    #1;
  endtask
endmodule

// ===== tb/tb_uar_rx_recovery.sv
// Self-checking bench of the receive recovery block and its serial partner.
`timescale 1ns/10ps
module tb_uar_rx_recovery;
  import uar_pkg::*;
  logic       clk_sys_in;   // System clock.
  logic       rstn_in;      // Reset, active low.
  logic       tick = 1'b0;  // Sample strobe, every second cycle.
  logic       ce;           // Clock enable.
  logic       dbl;          // Double-speed select.
  logic       en;           // Receiver enable.
  logic       ready;        // Consumer ready.
  logic [3:0] fbits;        // Data plus parity bits.
  logic       line;         // Serial line.
  logic       valid;        // Frame offered.
  logic       fe;           // Frame error flag.
  logic       ovr;          // Overrun pulse.
  logic       busy;         // Frame in progress.
  uar_word_t  word;         // Offered frame.
  int         err_count;    // Mismatches.
  int         total_checks; // Comparisons.
  int         ovr_seen = 0; // Overrun pulses counted.

  uar_rx_recovery u_uar_rx_recovery (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .clk_en_in(ce),
    .sample_tick_in(tick), .double_speed_select_in(dbl), .receiver_enable_in(en),
    .serial_receive_line_in(line), .frame_bits_in(fbits), .rx_valid_out(valid),
    .rx_ready_in(ready), .rx_word_out(word), .frame_error_flag_out(fe),
    .overrun_out(ovr), .rx_busy_out(busy));

  uar_tx_model u_uar_tx_model (.clk_sys_in(clk_sys_in), .line_out(line));

  // ****************************************************************
  // Clock, strobe and monitors
  // ****************************************************************

  // Clock of 4 ns period.
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  // One sample strobe every second cycle.
  always @(posedge clk_sys_in) tick <= #1 ~tick;

  // Counts overrun pulses.
  always @(negedge clk_sys_in) if (ovr === 1'b1) ovr_seen++;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Waits n edges, then lets their updates land.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  // Compares one flag.
  task automatic chk_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Compares one word.
  task automatic chk_word(input string nm, input uar_word_t e, input uar_word_t g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Waits for a word under a bound, checks it and takes it.
  task automatic get_word(input uar_word_t e);
    int k;
    k = 0;
    while (valid !== 1'b1 && k < 3000) begin
      cyc(1);
      k++;
    end
    chk_bit("rx_valid", 1'b1, valid);
    chk_word("rx_word", e, word);
    chk_bit("frame_error_flag", e.frame_error, fe);
    ready = 1'b1;
    cyc(1);
    ready = 1'b0;
    cyc(1);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************

  // Normal speed, one flipped sample mid-bit, two stop bits.
  task automatic t_basic();
    u_uar_tx_model.send(10'h0a5, 8, 1'b1, 32, 64, 2);
    get_word({1'b0, 10'h0a5});
  endtask

  // Sender slightly fast and slightly slow.
  task automatic t_rates();
    u_uar_tx_model.send(10'h03c, 8, 1'b1, 31, 31, -1);
    get_word({1'b0, 10'h03c});
    u_uar_tx_model.send(10'h0c3, 8, 1'b1, 33, 33, -1);
    get_word({1'b0, 10'h0c3});
  endtask

  // Double speed at both frame size limits.
  task automatic t_double();
    dbl = 1'b1;
    fbits = 4'h5;
    u_uar_tx_model.send(10'h015, 5, 1'b1, 16, 16, -1);
    get_word({1'b0, 10'h015});
    fbits = 4'ha;
    u_uar_tx_model.send(10'h2b6, 10, 1'b1, 16, 16, -1);
    get_word({1'b0, 10'h2b6});
    dbl = 1'b0;
    fbits = 4'h8;
  endtask

  // A short spike is dropped, the next real frame is taken.
  task automatic t_noise();
    u_uar_tx_model.spike(4);
    cyc(40);
    chk_bit("rx_busy", 1'b0, busy);
    chk_bit("rx_valid", 1'b0, valid);
    u_uar_tx_model.send(10'h081, 8, 1'b1, 32, 32, -1);
    get_word({1'b0, 10'h081});
  endtask

  // Stop bit low gives a frame error; its low tail must not open a frame.
  task automatic t_ferr();
    u_uar_tx_model.send(10'h0ff, 8, 1'b0, 32, 32, -1);
    chk_bit("rx_busy", 1'b0, busy);
    get_word({1'b1, 10'h0ff});
    cyc(40);
  endtask

  // Short stop bits back to back into a stalled consumer.
  task automatic t_fill();
    int ovr_base;
    ovr_base = ovr_seen;
    u_uar_tx_model.send(10'h011, 8, 1'b1, 32, 24, -1);
    u_uar_tx_model.send(10'h022, 8, 1'b1, 32, 24, -1);
    u_uar_tx_model.send(10'h033, 8, 1'b1, 32, 24, -1);
    cyc(40);
    chk_bit("overrun_once", 1'b1, (ovr_seen - ovr_base) == 1);
    get_word({1'b0, 10'h011});
    get_word({1'b0, 10'h022});
    chk_bit("rx_valid", 1'b0, valid);
  endtask

  // Clock enable freezes a held word; disable mid-frame drops frame and word.
  task automatic t_abort();
    u_uar_tx_model.send(10'h05a, 8, 1'b1, 32, 32, -1);
    cyc(20);
    ce = 1'b0;
    ready = 1'b1;
    cyc(3);
    chk_bit("rx_valid_frozen", 1'b1, valid);
    chk_word("rx_word_frozen", {1'b0, 10'h05a}, word);
    ready = 1'b0;
    ce = 1'b1;
    cyc(1);
    fork
      u_uar_tx_model.send(10'h077, 8, 1'b1, 32, 32, -1);
    join_none
    cyc(120);
    chk_bit("rx_busy_before", 1'b1, busy);
    chk_bit("rx_valid_before", 1'b1, valid);
    en = 1'b0;
    cyc(1);
    chk_bit("rx_busy", 1'b0, busy);
    chk_bit("rx_valid", 1'b0, valid);
    cyc(300);
    en = 1'b1;
    cyc(60);
    chk_bit("rx_valid_after", 1'b0, valid);
  endtask

  // ****************************************************************
  // Run control
  // ****************************************************************

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Cuts a hang short well past the expected run time.
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    rstn_in = 1'b0;
    ce = 1'b1;
    dbl = 1'b0;
    en = 1'b1;
    ready = 1'b0;
    fbits = 4'h8;
    err_count = 0;
    total_checks = 0;
    cyc(4);
    rstn_in = 1'b1;
    cyc(4);
    t_basic();
    t_rates();
    t_double();
    t_noise();
    t_ferr();
    t_fill();
    t_abort();
    report_and_stop();
  end
endmodule
